//--- logic/srrs_defines.svh
// register map, field positions, reset values and timing counts
`ifndef SRRS_DEFINES_SVH
`define SRRS_DEFINES_SVH

`define SRRS_ADR_W 12
`define SRRS_OFS_STATUS 12'hFF0
`define SRRS_OFS_PWRCTL 12'hF80
`define SRRS_OFS_LVDIRQ 12'hF84

`define SRRS_BIT_POWER 3
`define SRRS_BIT_STOP 2
`define SRRS_BIT_WDOG 1
`define SRRS_BIT_EXT 0
`define SRRS_PWR_LVD_OFF 4

`define SRRS_RST_FLAGS 4'h8
`define SRRS_RST_PWRCTL 8'h80
`define SRRS_FLAGS_DEBUG 4'h8
`define SRRS_FLAGS_EXT 4'h1
`define SRRS_FLAGS_WDOG 4'h2

`define SRRS_RECOVERY_CYCLES 4
`define SRRS_EXT_MIN_CYCLES 4
`define SRRS_SYSRST_CYCLES 16

`endif

//--- logic/srrs_pkg.sv
// types shared by the stop-recovery and reset-status logic
package srrs_pkg;
    typedef enum logic [1:0] {
        SRRS_RUN,
        SRRS_STOP,
        SRRS_RECOVER,
        SRRS_SYSRST
    } srrs_state_e;
    typedef logic [3:0] srrs_flags_t;
endpackage : srrs_pkg

//--- logic/srrs_top.sv
// stop-mode recovery sequencer and reset-cause status register
// Function
// R1 - watchdog timeout in stop runs recovery, sets watchdog and stop flags
// R2 - watchdog interrupt served only after recovery completes
// R3 - stop-enabled timer interrupt wakes, sets stop, served after
// R4 - stop-enabled comparator interrupt wakes, sets stop, served after
// R5 - either-edge change on wake-enabled gpio starts recovery, sets stop
// R6 - port input values frozen in stop, captured only after recovery ends
// R7 - reset pin low in stop gives system reset; short pulses ignored
// R8 - bit 0 shows live low-supply state, unaffected by reads or writes
// R9 - low-supply interrupt raised when enabled
// R10 - power control bit 4 switches low-supply detector on or off
// R11 - status register read-only, read clears upper four flags
// R12 - power flag set by por/brownout, cleared by watchdog, recovery, read
// R13 - stop flag set on recovery, cleared by por, run-mode watchdog, read
// R14 - watchdog flag set on timeout, cleared by por, gpio recovery, read
// R15 - software reads status before clearing watchdog interrupt
// R16 - external flag set by reset pin, cleared by por, gpio recovery, read
// R17 - run-mode watchdog reset leaves flags 0,0,1,0
// R18 - debugger control reset leaves flags 1,0,0,0
// R19 - debug pin reset out of stop leaves flags 1,0,0,0
// R20 - recovery holds cpu reset four oscillator cycles, then selects oscillator
// R21 - reserved status bits 3 to 1 read zero
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "srrs_defines.svh"

module srrs_top #(
    parameter int GPIO_W = 8,
    parameter int SYSRST_CYCLES = `SRRS_SYSRST_CYCLES
) (
    // clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SRRS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core and configuration
    input wire logic stop_req_i,
    input wire logic irq_enable_i,
    input wire logic wdt_irq_mode_i,
    input wire logic timer_stop_en_i,
    input wire logic comp_stop_en_i,
    input wire logic [GPIO_W-1:0] gpio_wake_en_i,
    // wake and reset sources
    input wire logic wdt_timeout_i,
    input wire logic timer_irq_i,
    input wire logic comp_irq_i,
    input wire logic [GPIO_W-1:0] gpio_i,
    input wire logic ext_reset_n_i,
    input wire logic debug_pin_n_i,
    input wire logic debugger_reset_i,
    input wire logic brownout_i,
    input wire logic low_supply_i,
    // sequencing outputs
    output logic stop_mode_o,
    output logic cpu_reset_o,
    output logic sys_reset_o,
    output logic osc_select_o,
    output logic [2:0] wake_irq_o,
    output logic [GPIO_W-1:0] port_input_value_o,
    output logic low_supply_enable_o,
    output logic lvd_irq_o
);
    import srrs_pkg::*;

    if (GPIO_W < 1 || GPIO_W > 32) begin : g_chk
        $error("srrs_top: GPIO_W must be 1..32");
    end
    if (SYSRST_CYCLES < 1 || SYSRST_CYCLES > 255) begin : g_chk2
        $error("srrs_top: SYSRST_CYCLES must be 1..255");
    end

    function automatic logic hit(input logic [`SRRS_ADR_W-1:0] a,
                                 input logic [`SRRS_ADR_W-1:0] o);
        hit = (a[`SRRS_ADR_W-1:2] == o[`SRRS_ADR_W-1:2]);
    endfunction : hit

    srrs_state_e state_q, state_d;
    srrs_flags_t flags_q, flags_d;
    logic [7:0] pwrctl_q;
    logic lvdirq_en_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] cnt_q, cnt_d;
    logic [2:0] ext_cnt_q;
    logic [GPIO_W-1:0] gpio_snap_q;
    logic [GPIO_W-1:0] port_q;
    logic [2:0] pend_q;
    logic [2:0] wake_irq_q;
    logic osc_sel_q;

    // bus decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire hit_status = hit(wb_adr_i, `SRRS_OFS_STATUS);
    wire hit_pwr = hit(wb_adr_i, `SRRS_OFS_PWRCTL);
    wire hit_lvd = hit(wb_adr_i, `SRRS_OFS_LVDIRQ);
    wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
    // R11 read clears flags
    wire status_rd = req & ~wb_we_i & hit_status;

    // R10 detector enable, bit set means off
    wire lvd_on = ~pwrctl_q[`SRRS_PWR_LVD_OFF];
    // R8 live low-supply bit
    wire lvd_live = lvd_on & low_supply_i;
    // R21 reserved bits zero
    wire [7:0] status_byte = {flags_q, 3'b000, lvd_live};

    wire [31:0] rd_data = hit_status ? {24'h000000, status_byte} :
                          hit_pwr ? {24'h000000, pwrctl_q} :
                          hit_lvd ? {31'h00000000, lvdirq_en_q} :
                          32'h00000000;

    // source classification
    wire in_stop = (state_q == SRRS_STOP);
    wire active = (state_q != SRRS_SYSRST);
    // R7 reset pin glitch filter
    wire ext_trip = ~ext_reset_n_i &&
        (ext_cnt_q == 3'(`SRRS_EXT_MIN_CYCLES - 1));
    // R19 debug pin only acts in stop
    wire dbg_pin = in_stop & ~debug_pin_n_i;
    // R18 debugger control reset
    wire dbg_rst = active & (debugger_reset_i | dbg_pin);
    wire ext_rst = active & ext_trip;
    wire wdt_run = active & ~in_stop & wdt_timeout_i;
    // R17 run-mode watchdog reset
    wire wdt_run_rst = wdt_run & ~wdt_irq_mode_i;
    // R5 either-edge change on enabled pins
    wire gpio_chg = |((gpio_i ^ gpio_snap_q) & gpio_wake_en_i);
    wire hard = brownout_i | dbg_rst | ext_rst | wdt_run_rst;
    wire wake_wdt = in_stop & wdt_timeout_i;
    wire wake_tmr = in_stop & timer_irq_i & timer_stop_en_i;
    wire wake_cmp = in_stop & comp_irq_i & comp_stop_en_i;
    wire wake_gpio = in_stop & gpio_chg;
    wire rec = ~hard & (wake_wdt | wake_tmr | wake_cmp | wake_gpio);
    wire rec_gpio = rec & wake_gpio & ~wake_wdt;
    wire pwr_evt = brownout_i | dbg_rst;

    // flag set masks
    wire [3:0] set_m = {pwr_evt, rec & ~pwr_evt,
                        (wake_wdt & rec) | wdt_run,
                        ext_rst & ~pwr_evt};
    // flag clear masks
    wire [3:0] clr_m = {
        // R12 power flag clears
        wdt_run | rec | ext_rst | status_rd,
        // R13 stop flag clears
        wdt_run | ext_rst | pwr_evt | status_rd,
        // R14 watchdog flag clears
        rec_gpio | ext_rst | pwr_evt | status_rd,
        // R16 external flag clears
        rec_gpio | wdt_run | pwr_evt | status_rd};

    // set wins over clear, read clear included
    always_comb begin
        flags_d = (flags_q & ~clr_m) | set_m;
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SRRS_RUN: begin
                if (hard) begin
                    state_d = SRRS_SYSRST;
                    cnt_d = 8'(SYSRST_CYCLES - 1);
                end else if (stop_req_i) begin
                    state_d = SRRS_STOP;
                end
            end
            SRRS_STOP: begin
                // R7 pin reset instead of recovery
                if (hard) begin
                    state_d = SRRS_SYSRST;
                    cnt_d = 8'(SYSRST_CYCLES - 1);
                end else if (rec) begin
                    // R20 four-cycle cpu hold
                    state_d = SRRS_RECOVER;
                    cnt_d = 8'(`SRRS_RECOVERY_CYCLES - 1);
                end
            end
            SRRS_RECOVER: begin
                if (hard) begin
                    state_d = SRRS_SYSRST;
                    cnt_d = 8'(SYSRST_CYCLES - 1);
                end else if (cnt_q == 8'h00) begin
                    state_d = SRRS_RUN;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            SRRS_SYSRST: begin
                // held while the pin stays low
                if (brownout_i || !ext_reset_n_i) begin
                    cnt_d = 8'(SYSRST_CYCLES - 1);
                end else if (cnt_q == 8'h00) begin
                    state_d = SRRS_RUN;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = SRRS_RUN;
            end
        endcase
    end

    wire rec_done = (state_q == SRRS_RECOVER) && (cnt_q == 8'h00) && !hard;
    // R2 R3 R4 pending wake requests
    wire [2:0] pend_new = {wake_wdt & wdt_irq_mode_i, wake_tmr, wake_cmp};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SRRS_RUN;
            cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // R1 R12 R13 R14 R16 flag register, por value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= `SRRS_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // bus registers, ack one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            pwrctl_q <= `SRRS_RST_PWRCTL;
            lvdirq_en_q <= 1'b0;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                dat_q <= rd_data;
            end
            if (wr_lane0 && hit_pwr) begin
                pwrctl_q <= wb_dat_i[7:0];
            end
            if (wr_lane0 && hit_lvd) begin
                lvdirq_en_q <= wb_dat_i[0];
            end
        end
    end

    // reset pin low-width counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_cnt_q <= 3'b000;
        end else if (ext_reset_n_i) begin
            ext_cnt_q <= 3'b000;
        end else if (ext_cnt_q != 3'(`SRRS_EXT_MIN_CYCLES)) begin
            ext_cnt_q <= ext_cnt_q + 3'b001;
        end
    end

    // pin snapshot taken on stop entry; port values frozen in stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio_snap_q <= '0;
            port_q <= '0;
        end else begin
            if (state_q == SRRS_RUN && state_d == SRRS_STOP) begin
                gpio_snap_q <= gpio_i;
            end
            // R6 capture only outside stop and recovery
            if (state_q == SRRS_RUN) begin
                port_q <= gpio_i;
            end
        end
    end

    // wake requests wait until recovery is over
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 3'b000;
            wake_irq_q <= 3'b000;
            osc_sel_q <= 1'b0;
        end else begin
            wake_irq_q <= 3'b000;
            osc_sel_q <= rec_done;
            if (hard) begin
                pend_q <= 3'b000;
            end else if (rec_done) begin
                // R2 service after recovery only
                wake_irq_q <= irq_enable_i ? pend_q : 3'b000;
                pend_q <= 3'b000;
            end else if (rec) begin
                pend_q <= pend_new;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign stop_mode_o = in_stop;
    assign cpu_reset_o = (state_q == SRRS_RECOVER) ||
                         (state_q == SRRS_SYSRST);
    assign sys_reset_o = (state_q == SRRS_SYSRST);
    assign osc_select_o = osc_sel_q;
    assign wake_irq_o = wake_irq_q;
    assign port_input_value_o = port_q;
    assign low_supply_enable_o = lvd_on;
    // R9 low-supply interrupt; level, not latched
    assign lvd_irq_o = lvd_live & lvdirq_en_q;

    // checks
    a_wdt_stop_flags: assert property (@(posedge clk_i) // R1
        disable iff (rst_i) wake_wdt && rec |=> flags_q[2:1] == 2'b11)
        else $error("watchdog wake did not set stop and watchdog");
    a_irq_after_rec: assert property (@(posedge clk_i) // R2
        disable iff (rst_i)
        wake_irq_o != 3'b000 |-> $past(state_q == SRRS_RECOVER))
        else $error("wake interrupt before recovery end");
    a_timer_wake: assert property (@(posedge clk_i) // R3
        disable iff (rst_i)
        wake_tmr && !hard |=> flags_q[2] && state_q == SRRS_RECOVER)
        else $error("timer wake did not start recovery");
    a_cmp_wake: assert property (@(posedge clk_i) // R4
        disable iff (rst_i) wake_cmp && !hard |=> flags_q[2] && cpu_reset_o)
        else $error("comparator wake did not start recovery");
    a_gpio_wake: assert property (@(posedge clk_i) // R5
        disable iff (rst_i)
        rec_gpio && !pwr_evt |=> flags_q[2] && flags_q[0] == 1'b0)
        else $error("gpio wake flags wrong");
    a_port_frozen: assert property (@(posedge clk_i) // R6
        disable iff (rst_i)
        in_stop |=> port_input_value_o == $past(port_input_value_o))
        else $error("port value changed in stop");
    a_ext_filter: assert property (@(posedge clk_i) // R7
        disable iff (rst_i)
        ext_trip |-> !ext_reset_n_i && $past(!ext_reset_n_i, 3))
        else $error("reset pin tripped on short pulse");
    a_lvd_live: assert property (@(posedge clk_i) // R8
        disable iff (rst_i)
        status_byte[0] == (low_supply_i && !pwrctl_q[4]))
        else $error("low-supply bit not live");
    a_lvd_off: assert property (@(posedge clk_i) // R10
        disable iff (rst_i)
        pwrctl_q[`SRRS_PWR_LVD_OFF] |-> !lvd_irq_o && !status_byte[0])
        else $error("low-supply detector not switched off");
    a_read_clear: assert property (@(posedge clk_i) // R11
        disable iff (rst_i)
        status_rd && set_m == 4'h0 |=> flags_q == 4'h0 && wb_ack_o)
        else $error("status read did not clear flags");
    a_run_wdt_clear: assert property (@(posedge clk_i) // R13
        disable iff (rst_i) wdt_run |=> flags_q[2:1] == 2'b01)
        else $error("run watchdog did not clear stop flag");
    a_ext_flag: assert property (@(posedge clk_i) // R16
        disable iff (rst_i)
        ext_rst && !pwr_evt |=> flags_q[3:2] == 2'b00 && flags_q[0])
        else $error("reset pin flags wrong");
    a_wdt_run_rst: assert property (@(posedge clk_i) // R17
        disable iff (rst_i)
        wdt_run_rst && !pwr_evt && !ext_rst |=> flags_q == 4'h2)
        else $error("run watchdog reset flags wrong");
    a_debug_rst: assert property (@(posedge clk_i) // R18
        disable iff (rst_i) dbg_rst |=> flags_q == 4'h8 && sys_reset_o)
        else $error("debug reset flags wrong");
    a_rec_hold: assert property (@(posedge clk_i) // R20
        disable iff (rst_i)
        rec ##1 (!hard) [*4] |=> osc_select_o && !cpu_reset_o &&
            $past(cpu_reset_o) && $past(cpu_reset_o, 2) &&
            $past(cpu_reset_o, 3) && $past(cpu_reset_o, 4))
        else $error("recovery hold not four cycles");
    a_reserved_zero: assert property (@(posedge clk_i) // R21
        disable iff (rst_i)
        wb_ack_o && $past(status_rd) |-> wb_dat_o[3:1] == 3'b000)
        else $error("reserved status bits not zero");
endmodule : srrs_top

`default_nettype wire

//--- tb/srrs_src_model.sv
// wake and reset source model on the far side of the recovery block
`timescale 1ns/1ps
`default_nettype none
module srrs_src_model (
    // clock and command
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [2:0] cmd_i,
    input wire logic [3:0] len_i,
    input wire logic [2:0] svc_i,
    // source lines
    output logic wdt_timeout_o,
    output logic timer_irq_o,
    output logic comp_irq_o,
    output logic gpio0_o,
    output logic ext_reset_n_o,
    output logic debug_pin_n_o,
    output logic debugger_reset_o
);
    logic [3:0] low_q;
    logic dbg_q;
    assign ext_reset_n_o = !(low_q != 4'h0 && !dbg_q);
    assign debug_pin_n_o = !(low_q != 4'h0 && dbg_q);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_timeout_o <= 1'b0;
            debugger_reset_o <= 1'b0;
            timer_irq_o <= 1'b0;
            comp_irq_o <= 1'b0;
            gpio0_o <= 1'b0;
            low_q <= 4'h0;
            dbg_q <= 1'b0;
        end else begin
            wdt_timeout_o <= go_i && cmd_i == 3'h0;
            debugger_reset_o <= go_i && cmd_i == 3'h6;
            // one-cycle glitch: wakes but must not be captured
            gpio0_o <= go_i && cmd_i == 3'h3;
            // requests stay pending until the core serves them
            if (go_i && cmd_i == 3'h1) begin
                timer_irq_o <= 1'b1;
            end else if (svc_i[1]) begin
                timer_irq_o <= 1'b0;
            end
            if (go_i && cmd_i == 3'h2) begin
                comp_irq_o <= 1'b1;
            end else if (svc_i[0]) begin
                comp_irq_o <= 1'b0;
            end
            if (go_i && (cmd_i == 3'h4 || cmd_i == 3'h5)) begin
                low_q <= len_i;
                dbg_q <= cmd_i == 3'h5;
            end else if (low_q != 4'h0) begin
                low_q <= low_q - 4'h1;
            end
        end
    end
endmodule : srrs_src_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for stop recovery and reset-cause status
`timescale 1ns/1ps
`default_nettype none
`include "srrs_defines.svh"
module tb_top;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, go;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel, len;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic stop_req, irq_en, wdt_mode, tmr_en, cmp_en, gpio1, low_sup;
    logic wdt_to, tmr_irq, cmp_irq, gpio0, ext_n, dbg_n, dbgr, bo;
    logic stop_mode, cpu_rst, sys_rst, osc_sel, lse, lvd_irq;
    logic [2:0] cmd, wake_irq, irq;
    logic [7:0] piv;
    int bad_count, checks_done, cyc_n, rc, oc;
    srrs_top #(.SYSRST_CYCLES(3)) u_srrs_top (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .stop_req_i(stop_req),
        .irq_enable_i(irq_en), .wdt_irq_mode_i(wdt_mode),
        .timer_stop_en_i(tmr_en), .comp_stop_en_i(cmp_en),
        .gpio_wake_en_i(8'h01), .wdt_timeout_i(wdt_to),
        .timer_irq_i(tmr_irq), .comp_irq_i(cmp_irq),
        .gpio_i({6'h00, gpio1, gpio0}), .ext_reset_n_i(ext_n),
        .debug_pin_n_i(dbg_n), .debugger_reset_i(dbgr), .brownout_i(bo),
        .low_supply_i(low_sup), .stop_mode_o(stop_mode), .cpu_reset_o(cpu_rst),
        .sys_reset_o(sys_rst), .osc_select_o(osc_sel), .wake_irq_o(wake_irq),
        .port_input_value_o(piv), .low_supply_enable_o(lse),
        .lvd_irq_o(lvd_irq));
    srrs_src_model u_srrs_src_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .cmd_i(cmd), .len_i(len), .svc_i(wake_irq), .wdt_timeout_o(wdt_to),
        .timer_irq_o(tmr_irq), .comp_irq_o(cmp_irq), .gpio0_o(gpio0),
        .ext_reset_n_o(ext_n), .debug_pin_n_o(dbg_n),
        .debugger_reset_o(dbgr));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= {24'h000000, d};
        // only the bench timeout ends a missing acknowledge
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    task automatic fire(input logic [2:0] c, input logic [3:0] l);
        @(posedge clk_i);
        go <= 1'b1;
        cmd <= c;
        len <= l;
        @(posedge clk_i);
        go <= 1'b0;
    endtask : fire
    task automatic enter_stop();
        @(posedge clk_i);
        stop_req <= 1'b1;
        @(posedge clk_i);
        stop_req <= 1'b0;
        @(posedge clk_i);
        #1 chk(stop_mode, 1);
    endtask : enter_stop
    // counts reset cycles and grabs the released requests
    task automatic watch();
        rc = 0;
        oc = 0;
        irq = 3'b000;
        repeat (20) begin
            @(posedge clk_i);
            #1;
            if (cpu_rst === 1'b1) rc++;
            if (osc_sel === 1'b1) begin
                oc++;
                irq = wake_irq;
            end
        end
    endtask : watch
    task automatic wait_sys();
        repeat (40) @(posedge clk_i);
    endtask : wait_sys
    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // a hang ends the run as a failure
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, go, stop_req, irq_en, wdt_mode} = 7'h00;
        {tmr_en, cmp_en, gpio1, low_sup, bo} = 5'h00;
        wb_adr = 12'h000;
        wb_sel = 4'h1;
        wb_wdat = 32'h00000000;
        cmd = 3'h0;
        len = 4'h0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h80);
        wb(1, `SRRS_OFS_STATUS, 8'hFF);
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h00);
        wb(0, 12'h100, 8'h00); chk(rd, 32'h00);
        low_sup <= 1'b1;
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h01);
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h01);
        wb(1, `SRRS_OFS_LVDIRQ, 8'h01);
        #1 chk(lvd_irq, 1);
        wb(1, `SRRS_OFS_PWRCTL, 8'h90);
        #1 chk({lse, lvd_irq}, 0);
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h00);
        wb(1, `SRRS_OFS_PWRCTL, 8'h80);
        low_sup <= 1'b0;
        // short pin pulse in stop is filtered, a long one resets
        enter_stop();
        fire(3'h4, 4'h3);
        repeat (8) @(posedge clk_i);
        #1 chk({sys_rst, stop_mode}, 1);
        fire(3'h4, 4'h6);
        wait_sys();
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h10);
        wdt_mode <= 1'b1;
        fire(3'h0, 4'h0);
        repeat (3) @(posedge clk_i);
        enter_stop();
        gpio1 <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk(piv[1], 0);
        chk(stop_mode, 1);
        fire(3'h3, 4'h0);
        watch();
        chk(rc, 4);
        chk(oc, 1);
        #1 chk(piv, 8'h02);
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h40);
        enter_stop();
        fire(3'h3, 4'h0);
        watch();
        chk(rc, 4);
        wdt_mode <= 1'b0;
        fire(3'h0, 4'h0);
        wait_sys();
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h20);
        fire(3'h6, 4'h0);
        wait_sys();
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h80);
        enter_stop();
        fire(3'h5, 4'h6);
        wait_sys();
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h80);
        bo <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1 chk({sys_rst, cpu_rst}, 2'b11);
        bo <= 1'b0;
        wait_sys();
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h80);
        fire(3'h6, 4'h0);
        wait_sys();
        {irq_en, wdt_mode, tmr_en, cmp_en} <= 4'hF;
        enter_stop();
        fire(3'h0, 4'h0);
        watch();
        chk(irq, 3'b100);
        // status read before the watchdog request is cleared
        wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h60);
        for (int k = 1; k < 3; k++) begin
            enter_stop();
            fire(k[2:0], 4'h0);
            watch();
            chk(irq, (k == 1) ? 3'b010 : 3'b001);
            chk(oc, 1);
            wb(0, `SRRS_OFS_STATUS, 8'h00); chk(rd, 32'h40);
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
